// [pwmcc_pkg.sv]
// Purpose: shared constants and types of the pwm channel mode and phase control block
// Assumes: 32-bit apb data, each register one aligned word, 16 data bits used
// Notes: offsets are byte addresses
`default_nettype none
package pwmcc_pkg;
  localparam int DW = 16;
  localparam int AW = 12;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [AW-1:0] OFF_DUTY = 12'h004;
  localparam logic [AW-1:0] OFF_PHASE = 12'h008;
  localparam logic [AW-1:0] OFF_SPHASE = 12'h00C;
  localparam logic [AW-1:0] OFF_DTIME = 12'h010;
  localparam logic [AW-1:0] OFF_PERIOD = 12'h014;
  localparam logic [AW-1:0] OFF_OUTMODE = 12'h018;
  localparam logic [AW-1:0] OFF_INT_STAT = 12'h01C;
  localparam logic [AW-1:0] OFF_INT_MASK = 12'h020;
  localparam logic [AW-1:0] OFF_STATUS = 12'h024;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int B_IUE = 0;
  localparam int B_EXT_PERIOD_RESET_CTL = 1;
  localparam int B_CAM = 2;
  localparam int B_MASTER_TIMEBASE_SEL = 3;
  localparam int B_DTC_LO = 6;
  localparam int B_DTC_HI = 7;
  localparam int B_ITB = 9;
  localparam logic [DW-1:0] CTRL_WMASK = 16'h02CF;
  localparam logic [DW-1:0] REG_RESET = 16'h0000;
  localparam logic [DW-1:0] CENTER_LSB_MASK = 16'hFFF8;
  localparam logic [DW-1:0] CENTER_PERIOD_ADD = 16'h0004;
  localparam logic [DW-1:0] ONE = 16'h0001;
  // interrupt status bits
  localparam int N_EV = 3;
  localparam int EV_BOUNDARY = 0;
  localparam int EV_EXT_RESET = 1;
  localparam int EV_UPDATE = 2;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DTC_POS = 2'h0;
  localparam logic [1:0] DTC_NEG = 2'h1;
  localparam logic [1:0] DTC_OFF = 2'h2;
  localparam logic [1:0] OM_COMPL = 2'h0;
  localparam logic [1:0] OM_INDEP = 2'h3;
  typedef enum logic [1:0] {DT_POSITIVE, DT_NEGATIVE, DT_NONE} pwmcc_dt_t;
endpackage
`default_nettype wire

// [pwmcc_timebase.sv]
// Purpose: local pwm time base counter, edge or center aligned
// Assumes: i_tick is a one-cycle enable from the selected master time base
// Notes: o_boundary pulses once per period
`default_nettype none
module pwmcc_timebase import pwmcc_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_tick,
  input wire logic i_restart,
  input wire logic i_center,
  input wire logic [DW-1:0] i_period,
  // state
  output logic [DW-1:0] o_count,
  output logic o_down,
  output logic o_boundary
);
  logic [DW-1:0] count_reg, count_next;
  logic down_reg, down_next;
  logic wrap_up, wrap_down;

  assign wrap_up = (count_reg >= i_period);
  assign wrap_down = (count_reg == REG_RESET);
  // center mode counts up then down, one boundary at the bottom
  assign o_boundary = i_tick & ~i_restart & (i_center ? (down_reg & wrap_down) : wrap_up);

  always_comb begin
    count_next = count_reg;
    down_next = down_reg;
    if (i_restart) begin
      count_next = REG_RESET;
      down_next = 1'b0;
    end else if (i_tick) begin
      if (!i_center) begin
        down_next = 1'b0;
        count_next = wrap_up ? REG_RESET : count_reg + ONE;
      end else if (down_reg) begin
        down_next = ~wrap_down;
        count_next = wrap_down ? count_reg + ONE : count_reg - ONE;
      end else begin
        down_next = wrap_up;
        count_next = wrap_up ? count_reg - ONE : count_reg + ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= REG_RESET;
      down_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      down_reg <= down_next;
    end
  end

  assign o_count = count_reg;
  assign o_down = down_reg;
endmodule
`default_nettype wire

// [pwmcc_channel.sv]
// Purpose: per-channel pwm mode, update and phase control with apb registers
// Assumes: master time base ticks and syncs come from logic on i_clk
// Notes: current-limit input is asynchronous and is synchronised here
//
// What this block does
// - Dead-time field 00 gives positive dead time, 01 negative in complementary mode, 10 none, 11 reserved.
// - Master time base select picks the secondary master tick and sync when one and the secondary is present, else the primary.
// - Center-align enable chooses center-aligned counting when set, edge-aligned when clear.
// - Center-align enable is ignored unless independent time base is selected.
// - In center-aligned operation the low three bits of duty, phase and dead time are ignored.
// - With external reset enabled in independent mode a current-limit event restarts the time base.
// - Immediate update applies new values at once, otherwise synchronised to the local time base.
// - The secondary phase holds a 16-bit low-side value used only in independent output mode with independent time base.
// - With shared time base, modes 00-10 ignore secondary phase; mode 11 uses primary as low phase.
// - With independent time base and mode 11 the primary phase is the low-side period.
// - Control bits five and four always read zero.
//
// Design decisions made here: the APB register port and the placing of the registers.
`default_nettype none
module pwmcc_channel import pwmcc_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // master time bases
  input wire logic i_pri_tick,
  input wire logic i_pri_sync,
  input wire logic i_sec_tick,
  input wire logic i_sec_sync,
  input wire logic i_sec_present,
  // current-limit source pin
  input wire logic i_current_limit,
  // channel outputs
  output logic [DW-1:0] o_count,
  output logic o_center,
  output logic [DW-1:0] o_active_duty,
  output logic [DW-1:0] o_active_phase,
  output logic [DW-1:0] o_active_dtime,
  output logic [DW-1:0] o_low_phase,
  output logic [DW-1:0] o_low_period,
  output pwmcc_dt_t o_dead_mode,
  output logic o_pwm_high,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    hit = (a == off);
  endfunction

  logic setup, access, wr, rd, mapped;
  logic wr_ctrl, wr_duty, wr_phase, wr_sphase, wr_dtime, wr_period, wr_mode, wr_mask;
  logic rd_stat;
  logic [DW-1:0] wdata;

  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr = access & i_pwrite;
  assign rd = access & ~i_pwrite;
  assign wdata = i_pwdata[DW-1:0];
  assign mapped = hit(i_paddr, OFF_CTRL) | hit(i_paddr, OFF_DUTY) | hit(i_paddr, OFF_PHASE)
    | hit(i_paddr, OFF_SPHASE) | hit(i_paddr, OFF_DTIME) | hit(i_paddr, OFF_PERIOD)
    | hit(i_paddr, OFF_OUTMODE) | hit(i_paddr, OFF_INT_STAT) | hit(i_paddr, OFF_INT_MASK)
    | hit(i_paddr, OFF_STATUS);
  assign wr_ctrl = wr & hit(i_paddr, OFF_CTRL);
  assign wr_duty = wr & hit(i_paddr, OFF_DUTY);
  assign wr_phase = wr & hit(i_paddr, OFF_PHASE);
  assign wr_sphase = wr & hit(i_paddr, OFF_SPHASE);
  assign wr_dtime = wr & hit(i_paddr, OFF_DTIME);
  assign wr_period = wr & hit(i_paddr, OFF_PERIOD);
  assign wr_mode = wr & hit(i_paddr, OFF_OUTMODE);
  assign wr_mask = wr & hit(i_paddr, OFF_INT_MASK);
  assign rd_stat = rd & hit(i_paddr, OFF_INT_STAT);
  // zero wait states: the slave answers in the first access cycle
  assign o_pready = access;
  assign o_pslverr = access & ~mapped;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [DW-1:0] ctrl_reg, duty_reg, phase_reg, sphase_reg, dtime_reg, period_reg;
  logic [1:0] mode_reg;
  logic [N_EV-1:0] stat_reg, stat_next, mask_reg, events;
  logic [31:0] rdata_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= REG_RESET;
      duty_reg <= REG_RESET;
      phase_reg <= REG_RESET;
      sphase_reg <= REG_RESET;
      dtime_reg <= REG_RESET;
      period_reg <= REG_RESET;
      mode_reg <= OM_COMPL;
      mask_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata & CTRL_WMASK;
      if (wr_duty) duty_reg <= wdata;
      if (wr_phase) phase_reg <= wdata;
      if (wr_sphase) sphase_reg <= wdata;
      if (wr_dtime) dtime_reg <= wdata;
      if (wr_period) period_reg <= wdata;
      if (wr_mode) mode_reg <= wdata[1:0];
      if (wr_mask) mask_reg <= wdata[N_EV-1:0];
    end
  end

  logic independent_timebase_sel, center_align_en, ext_period_reset_ctl, immediate_update_en, master_timebase_sel;
  logic [1:0] dead_time_ctl;
  assign independent_timebase_sel = ctrl_reg[B_ITB];
  assign center_align_en = ctrl_reg[B_CAM];
  assign ext_period_reset_ctl = ctrl_reg[B_EXT_PERIOD_RESET_CTL];
  assign immediate_update_en = ctrl_reg[B_IUE];
  assign master_timebase_sel = ctrl_reg[B_MASTER_TIMEBASE_SEL];
  assign dead_time_ctl = ctrl_reg[B_DTC_HI:B_DTC_LO];

  // ----------------------------------------------------------------
  // time base selection and current-limit restart
  // ----------------------------------------------------------------
  logic use_sec, tb_tick, tb_sync, center_eff;
  logic cl_meta_reg, cl_sync_reg, cl_prev_reg, cl_event, ext_restart, tb_restart;

  // secondary only when it exists, so a missing one cannot stall the channel
  assign use_sec = master_timebase_sel & i_sec_present;
  assign tb_tick = use_sec ? i_sec_tick : i_pri_tick;
  assign tb_sync = use_sec ? i_sec_sync : i_pri_sync;
  assign center_eff = center_align_en & independent_timebase_sel;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cl_meta_reg <= 1'b0;
      cl_sync_reg <= 1'b0;
      cl_prev_reg <= 1'b0;
    end else begin
      cl_meta_reg <= i_current_limit;
      cl_sync_reg <= cl_meta_reg;
      cl_prev_reg <= cl_sync_reg;
    end
  end

  assign cl_event = cl_sync_reg & ~cl_prev_reg;
  // the pin has no effect while external reset is off
  assign ext_restart = cl_event & ext_period_reset_ctl & independent_timebase_sel;
  // a shared time base follows the master's sync; an independent one does not
  assign tb_restart = ext_restart | (~independent_timebase_sel & tb_sync);

  // ----------------------------------------------------------------
  // active values and update
  // ----------------------------------------------------------------
  logic [DW-1:0] act_duty_reg, act_phase_reg, act_sphase_reg, act_dtime_reg, act_period_reg;
  logic pend_reg, any_wr, boundary, apply;
  logic [DW-1:0] tb_period, cnt, lsb_mask;
  logic tb_down;

  assign any_wr = wr_duty | wr_phase | wr_sphase | wr_dtime | wr_period;
  assign apply = pend_reg & boundary;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_reg <= 1'b0;
    end else if (any_wr && !immediate_update_en) begin
      pend_reg <= 1'b1;
    end else if (apply || any_wr) begin
      // an immediate write copies every active value, so nothing stays pending
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      act_duty_reg <= REG_RESET;
      act_phase_reg <= REG_RESET;
      act_sphase_reg <= REG_RESET;
      act_dtime_reg <= REG_RESET;
      act_period_reg <= REG_RESET;
    end else if ((immediate_update_en && any_wr) || apply) begin
      // immediate mode copies on the write; otherwise at the boundary
      act_duty_reg <= immediate_update_en && wr_duty ? wdata : duty_reg;
      act_phase_reg <= immediate_update_en && wr_phase ? wdata : phase_reg;
      act_sphase_reg <= immediate_update_en && wr_sphase ? wdata : sphase_reg;
      act_dtime_reg <= immediate_update_en && wr_dtime ? wdata : dtime_reg;
      act_period_reg <= immediate_update_en && wr_period ? wdata : period_reg;
    end
  end

  // independent time base runs from its own period register
  assign tb_period = act_period_reg;

  pwmcc_timebase u_timebase (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_tick(tb_tick),
    .i_restart(tb_restart),
    .i_center(center_eff),
    .i_period(tb_period),
    .o_count(cnt),
    .o_down(tb_down),
    .o_boundary(boundary)
  );

  // ----------------------------------------------------------------
  // mode dependent outputs
  // ----------------------------------------------------------------
  logic indep_mode;
  logic [DW-1:0] duty_eff, phase_eff, sphase_eff, dtime_eff;
  pwmcc_dt_t dead_mode;

  assign lsb_mask = center_eff ? CENTER_LSB_MASK : ~REG_RESET;
  assign duty_eff = act_duty_reg & lsb_mask;
  assign phase_eff = act_phase_reg & lsb_mask;
  assign sphase_eff = act_sphase_reg & lsb_mask;
  assign dtime_eff = act_dtime_reg & lsb_mask;
  assign indep_mode = (mode_reg == OM_INDEP);

  // negative dead time exists only for complementary output; 11 acts as off
  assign dead_mode = (dead_time_ctl == DTC_POS) ? DT_POSITIVE :
    ((dead_time_ctl == DTC_NEG) && (mode_reg == OM_COMPL)) ? DT_NEGATIVE : DT_NONE;

  logic [DW-1:0] low_phase_reg, low_period_reg;
  logic [DW-1:0] low_phase_next, low_period_next;
  // secondary phase matters only with independent output and time base
  assign low_phase_next = (indep_mode && independent_timebase_sel) ? sphase_eff : phase_eff;
  // otherwise the low side shares the channel period
  assign low_period_next = (indep_mode && independent_timebase_sel) ? phase_eff : tb_period;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_phase_reg <= REG_RESET;
      low_period_reg <= REG_RESET;
      o_pwm_high <= 1'b0;
      o_dead_mode <= DT_POSITIVE;
    end else begin
      low_phase_reg <= low_phase_next;
      low_period_reg <= low_period_next;
      o_pwm_high <= (cnt < duty_eff);
      o_dead_mode <= dead_mode;
    end
  end

  assign o_count = cnt;
  assign o_center = center_eff;
  assign o_active_duty = duty_eff;
  assign o_active_phase = phase_eff;
  assign o_active_dtime = dtime_eff;
  assign o_low_phase = low_phase_reg;
  assign o_low_period = low_period_reg;

  // ----------------------------------------------------------------
  // interrupt status, read clears, set wins
  // ----------------------------------------------------------------
  assign events = {apply, ext_restart, boundary};
  // software clears here by reading; the controller flag is its own job
  // only the bits that the read returned clear, so a setup-edge event survives
  assign stat_next = (stat_reg & ~(rd_stat ? rdata_reg[N_EV-1:0] : '0)) | events;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [DW-1:0] rd_val;
  assign rd_val = hit(i_paddr, OFF_CTRL) ? ctrl_reg :
    hit(i_paddr, OFF_DUTY) ? duty_reg :
    hit(i_paddr, OFF_PHASE) ? phase_reg :
    hit(i_paddr, OFF_SPHASE) ? sphase_reg :
    hit(i_paddr, OFF_DTIME) ? dtime_reg :
    hit(i_paddr, OFF_PERIOD) ? period_reg :
    hit(i_paddr, OFF_OUTMODE) ? {14'h0000, mode_reg} :
    hit(i_paddr, OFF_INT_STAT) ? {13'h0000, stat_reg} :
    hit(i_paddr, OFF_INT_MASK) ? {13'h0000, mask_reg} :
    hit(i_paddr, OFF_STATUS) ? {14'h0000, tb_down, pend_reg} : REG_RESET;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 32'h00000000;
    end else if (setup && !i_pwrite) begin
      rdata_reg <= {16'h0000, rd_val};
    end
  end
  assign o_prdata = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_dead_time;
    @(posedge i_clk) disable iff (!i_resetn)
      (dead_time_ctl == DTC_OFF) |=> (o_dead_mode == DT_NONE);
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("dead time off not honoured");

  property p_tb_select;
    @(posedge i_clk) disable iff (!i_resetn)
      (!independent_timebase_sel && master_timebase_sel && i_sec_present && i_sec_sync && !ext_restart) |=> (cnt == REG_RESET);
  endproperty
  a_tb_select: assert property (p_tb_select) else $error("secondary sync ignored");

  property p_center_ignored;
    @(posedge i_clk) disable iff (!i_resetn)
      !independent_timebase_sel |-> !o_center;
  endproperty
  a_center_ignored: assert property (p_center_ignored) else $error("center without itb");

  property p_center_on;
    @(posedge i_clk) disable iff (!i_resetn)
      (independent_timebase_sel && center_align_en) |-> o_center;
  endproperty
  a_center_on: assert property (p_center_on) else $error("center mode not entered");

  property p_lsb;
    @(posedge i_clk) disable iff (!i_resetn)
      o_center |-> (o_active_duty[2:0] == 3'h0 && o_active_dtime[2:0] == 3'h0);
  endproperty
  a_lsb: assert property (p_lsb) else $error("low bits kept in center mode");

  property p_ext_reset;
    @(posedge i_clk) disable iff (!i_resetn)
      ($rose(cl_sync_reg) && ext_period_reset_ctl && independent_timebase_sel) |=> (cnt == REG_RESET) && stat_reg[EV_EXT_RESET];
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external reset missed");

  property p_immediate;
    @(posedge i_clk) disable iff (!i_resetn)
      (immediate_update_en && wr_duty) |=> (act_duty_reg == $past(wdata)) && !pend_reg;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate update late");

  property p_sync_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      (!immediate_update_en && wr_duty && !apply) |=> pend_reg && (act_duty_reg == $past(act_duty_reg));
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync update applied early");

  property p_low_period;
    @(posedge i_clk) disable iff (!i_resetn)
      (independent_timebase_sel && indep_mode) |=> (o_low_period == $past(phase_eff));
  endproperty
  a_low_period: assert property (p_low_period) else $error("low period not primary");

  property p_sphase_unused;
    @(posedge i_clk) disable iff (!i_resetn)
      !(indep_mode && independent_timebase_sel) |=> (o_low_phase == $past(phase_eff));
  endproperty
  a_sphase_unused: assert property (p_sphase_unused) else $error("secondary phase leaked");

  property p_ctrl_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      (setup && !i_pwrite && hit(i_paddr, OFF_CTRL)) |=> (o_prdata[5:4] == 2'h0);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("bits five and four nonzero");

  c_sync_apply: cover property (@(posedge i_clk) disable iff (!i_resetn) apply);
  c_ext_reset: cover property (@(posedge i_clk) disable iff (!i_resetn) ext_restart);
  c_center_turn: cover property (@(posedge i_clk) disable iff (!i_resetn) o_center && $rose(tb_down));
endmodule
`default_nettype wire

// [pwm_channel_mode_and_phase_control_test.sv]
// Purpose: self-checking bench of the pwm channel mode and phase control block
// Assumes: zero-wait apb slave, master ticks driven by the bench on the same clock
// Notes: expectations are built from register encodings, except the count snapshot c0 read back from the output
`default_nettype none
module pwm_channel_mode_and_phase_control_test import pwmcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR at %0t got %h expected %h", $time, (a), (e)); end end
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, last_err;
  logic pri_tick = 1'b0, pri_sync = 1'b0, sec_tick = 1'b0, sec_sync = 1'b0;
  logic sec_present = 1'b0, cur_lim = 1'b0;
  logic [DW-1:0] count, a_duty, a_phase, a_dtime, low_phase, low_period, c0;
  logic center, pwm_high, irq, seen;
  pwmcc_dt_t dead_mode;
  pwmcc_dt_t dt_exp [4] = '{DT_POSITIVE, DT_NEGATIVE, DT_NONE, DT_NONE};
  int error_cnt = 0;
  int check_count = 0;
  always #2 i_clk = ~i_clk;
  pwmcc_channel dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pri_tick(pri_tick), .i_pri_sync(pri_sync), .i_sec_tick(sec_tick),
    .i_sec_sync(sec_sync), .i_sec_present(sec_present), .i_current_limit(cur_lim),
    .o_count(count), .o_center(center), .o_active_duty(a_duty), .o_active_phase(a_phase),
    .o_active_dtime(a_dtime), .o_low_phase(low_phase), .o_low_period(low_period),
    .o_dead_mode(dead_mode), .o_pwm_high(pwm_high), .o_irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (pready === 1'b1) begin
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    `CHK(rd, {16'h0000, e})
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // bounded wait for a count value; gives up and counts a mismatch
  task automatic wait_count(input logic [DW-1:0] v);
    int n;
    n = 0;
    while (count !== v && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    `CHK(count, v)
  endtask
  // one master sync pulse at a known count, then one more edge
  task automatic pulse_sync(input logic sec);
    wait_count(16'h0004);
    sec_sync <= sec;
    pri_sync <= ~sec;
    cyc(1);
    sec_sync <= 1'b0;
    pri_sync <= 1'b0;
    cyc(1);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    i_resetn <= 1'b1;
    rd_chk(OFF_CTRL, 16'h0000);
    rd_chk(OFF_SPHASE, 16'h0000);
    wr(OFF_SPHASE, 16'hA5C3);
    rd_chk(OFF_SPHASE, 16'hA5C3);
    wr(OFF_CTRL, 16'hFFFF);
    rd_chk(OFF_CTRL, 16'h02CF);
    rd_chk(12'h040, 16'h0000);
    `CHK(last_err, 1'b1)
    // dead-time codes, complementary output mode
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CTRL, 16'h0201 | 16'(d << 6));
      cyc(3);
      `CHK(dead_mode, dt_exp[d])
    end
    wr(OFF_OUTMODE, 16'h0003);
    wr(OFF_CTRL, 16'h0241);
    cyc(3);
    `CHK(dead_mode, DT_NONE)
    wr(OFF_OUTMODE, 16'h0000);
    // center-align honoured only with independent time base
    wr(OFF_CTRL, 16'h0005);
    cyc(2);
    `CHK(center, 1'b0)
    wr(OFF_CTRL, 16'h0205);
    cyc(2);
    `CHK(center, 1'b1)
    wr(OFF_DUTY, 16'h1237);
    wr(OFF_PHASE, 16'h0019);
    wr(OFF_DTIME, 16'h00FF);
    cyc(2);
    `CHK(a_duty, 16'h1230)
    `CHK(a_phase, 16'h0018)
    `CHK(a_dtime, 16'h00F8)
    // synchronised update held until a period boundary, ticks stopped
    wr(OFF_CTRL, 16'h0201);
    wr(OFF_PERIOD, 16'h0010);
    wr(OFF_CTRL, 16'h0200);
    wr(OFF_INT_MASK, 16'h0004);
    rd_chk(OFF_INT_STAT, 16'h0000);
    wr(OFF_DUTY, 16'h0100);
    cyc(4);
    `CHK(a_duty, 16'h1237)
    rd_chk(OFF_STATUS, 16'h0001);
    `CHK(irq, 1'b0)
    pri_tick <= 1'b1;
    // count starts at zero: wait for the top, then the wrap
    wait_count(16'h0010);
    wait_count(16'h0000);
    cyc(2);
    `CHK(a_duty, 16'h0100)
    `CHK(irq, 1'b1)
    apb(1'b0, OFF_INT_STAT, 16'h0000);
    `CHK(rd[2], 1'b1)
    cyc(1);
    `CHK(irq, 1'b0)
    // current-limit restart only with ext reset and independent base
    wr(OFF_INT_MASK, 16'h0002);
    wr(OFF_CTRL, 16'h0203);
    wait_count(16'h0005);
    cur_lim <= 1'b1;
    seen = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      seen = seen | (count === 16'h0000);
    end
    `CHK(seen, 1'b1)
    `CHK(irq, 1'b1)
    apb(1'b0, OFF_INT_STAT, 16'h0000);
    `CHK(rd[1], 1'b1)
    cyc(1);
    `CHK(irq, 1'b0)
    cur_lim <= 1'b0;
    wr(OFF_CTRL, 16'h0201);
    wait_count(16'h0003);
    cur_lim <= 1'b1;
    seen = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      seen = seen | (count === 16'h0000);
    end
    `CHK(seen, 1'b0)
    `CHK(irq, 1'b0)
    // master time base selection; the write edge still ticks the old base
    sec_present <= 1'b1;
    wr(OFF_CTRL, 16'h0209);
    cyc(1);
    c0 = count;
    cyc(4);
    `CHK(count, c0)
    sec_tick <= 1'b1;
    cyc(4);
    `CHK(count !== c0, 1'b1)
    // shared time base follows only the selected master's sync
    wr(OFF_CTRL, 16'h0009);
    pulse_sync(1'b1);
    `CHK(count, 16'h0000)
    pulse_sync(1'b0);
    `CHK(count, 16'h0006)
    sec_present <= 1'b0;
    pulse_sync(1'b0);
    `CHK(count, 16'h0000)
    // low-side phase and period by output mode and time base
    wr(OFF_CTRL, 16'h0201);
    wr(OFF_PHASE, 16'h0040);
    wr(OFF_SPHASE, 16'h0128);
    wr(OFF_OUTMODE, 16'h0003);
    cyc(3);
    `CHK(low_phase, 16'h0128)
    `CHK(low_period, 16'h0040)
    wr(OFF_CTRL, 16'h0001);
    cyc(3);
    `CHK(low_phase, 16'h0040)
    wr(OFF_CTRL, 16'h0201);
    wr(OFF_OUTMODE, 16'h0000);
    cyc(3);
    `CHK(low_phase, 16'h0040)
    `CHK(low_period, 16'h0010)
    // high output while the edge-aligned count is below the duty
    wr(OFF_DUTY, 16'h0008);
    cyc(1);
    wait_count(16'h000A);
    cyc(1);
    `CHK(pwm_high, 1'b0)
    wait_count(16'h0003);
    cyc(1);
    `CHK(pwm_high, 1'b1)
    // center-aligned count turns down after the top
    wr(OFF_CTRL, 16'h0205);
    cyc(1);
    wait_count(16'h0010);
    cyc(2);
    `CHK(count, 16'h000E)
    end_sim();
  end
endmodule
`default_nettype wire
